// File: rtl/rba_fifo.sv
`timescale 1ns/1ns
module rba_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } rba_fifo_state_t;

  rba_fifo_state_t st_reg;
  rba_fifo_state_t st_next;
  logic            push;
  logic            pop;

  assign in_ready_o  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid_o = (st_reg.count != '0);
  assign out_data_o  = st_reg.mem[st_reg.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data_i;
      st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : rba_fifo

// File: rtl/rba_pkg.sv
package rba_pkg;

  typedef enum logic [2:0] {
    RBA_DEC_POOL,
    RBA_DEC_PRIV,
    RBA_DEC_NAK_UNAVAIL,
    RBA_DEC_NAK_SMALL,
    RBA_DEC_DISCARD
  } rba_dec_t;

  typedef enum logic [1:0] {
    RBA_RUN,
    RBA_DRAIN,
    RBA_DEAD
  } rba_mode_t;

  typedef struct packed {
    rba_mode_t  mode;
    logic       dec_valid;
    rba_dec_t   dec_kind;
    logic [1:0] dec_trib;
    logic       pool_pop;
    logic       priv_pop;
    logic       ret_priv;
    logic [1:0] ret_trib;
    logic       ret_pool;
    logic       overflow;
  } rba_top_state_t;

endpackage : rba_pkg

// File: rtl/rba_regs.svh
// Function
// - Unreachable buffer address on host bus produces a control response holding that address
// - Reported address may be the failing one or the next sequential location
// - Out-of-sequence messages are silently dropped before any buffer choice
// - Common pool tried only when enabled, quota nonzero and a buffer is available
// - Too-small pool buffer falls back to private list, else NAK too small
// - Pool unusable and no private buffer gives NAK temporarily unavailable
// - Too-small private buffer gives NAK too small, otherwise message stored there
// - Only the head entry of each list is taken, no size search
// - Too-small error applies to receive buffers only, never to transmit buffers
// - Halting a tributary returns all its outstanding buffers to the host
// - No free link block for an invalid-memory response raises queue overflow; other responses wait
// - Queue overflow is always fatal and leads to automatic shutdown
// - After overflow each response is presented with interrupt, host gets three seconds
// - Queue drained or read window expired: shut down until full restart
// - Repeated invalid-memory retransmission requests may overflow the queue, then fatal path
`ifndef RBA_REGS_SVH
`define RBA_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define RBA_NTRIB        4
`define RBA_TRIB_W       2
`define RBA_LEN_W        16
`define RBA_ADDR_W       18
`define RBA_RESP_W       20
`define RBA_RESP_DEPTH   16

// ----------------------------------------
// Response word layout
// ----------------------------------------
`define RBA_RESP_CODE_HI 19
`define RBA_RESP_CODE_LO 18
`define RBA_CODE_NXM     2'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define RBA_CLK_HZ       50000000
`define RBA_WINDOW_SEC   3
`define RBA_WINDOW_CYC   (`RBA_WINDOW_SEC * `RBA_CLK_HZ)
`define RBA_WDOG_W       28

`endif

// File: rtl/rba_top.sv
`timescale 1ns/1ns
`include "rba_regs.svh"
module rba_top #(
  parameter logic [`RBA_WDOG_W-1:0] WINDOW_CYCLES = `RBA_WDOG_W'(`RBA_WINDOW_CYC)
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     sys_rst_i,
  // Incoming receive message
  input  wire logic                     msg_valid_i,
  output logic                          msg_ready_o,
  input  wire logic                     msg_seq_ok_i,
  input  wire logic [`RBA_TRIB_W-1:0]   msg_trib_i,
  input  wire logic [`RBA_LEN_W-1:0]    msg_len_i,
  // Buffer list heads
  input  wire logic [`RBA_NTRIB-1:0]    pool_en_i,
  input  wire logic [7:0]               pool_quota_i,
  input  wire logic                     pool_avail_i,
  input  wire logic [`RBA_LEN_W-1:0]    pool_size_i,
  input  wire logic                     priv_avail_i,
  input  wire logic [`RBA_LEN_W-1:0]    priv_size_i,
  // Decision
  output logic                          dec_valid_o,
  output rba_pkg::rba_dec_t             dec_kind_o,
  output logic [`RBA_TRIB_W-1:0]        dec_trib_o,
  output logic                          pool_pop_o,
  output logic                          priv_pop_o,
  // Halt commands and buffer return
  input  wire logic                     halt_i,
  input  wire logic [`RBA_TRIB_W-1:0]   halt_trib_i,
  input  wire logic                     global_halt_i,
  output logic                          ret_priv_o,
  output logic [`RBA_TRIB_W-1:0]        ret_trib_o,
  output logic                          ret_pool_o,
  // Invalid memory report from buffer access
  input  wire logic                     nxm_i,
  input  wire logic [`RBA_ADDR_W-1:0]   nxm_addr_i,
  // Other responses
  input  wire logic                     ext_valid_i,
  output logic                          ext_ready_o,
  input  wire logic [`RBA_RESP_W-1:0]   ext_data_i,
  // Host response port
  output logic                          resp_valid_o,
  output logic [`RBA_RESP_W-1:0]        resp_data_o,
  input  wire logic                     host_rd_i,
  output logic                          host_int_o,
  output logic                          overflow_o,
  output logic                          shutdown_o
);
  rba_pkg::rba_top_state_t st_reg;
  rba_pkg::rba_top_state_t st_next;

  logic                   f_in_valid;
  logic                   f_in_ready;
  logic [`RBA_RESP_W-1:0] f_in_data;
  logic                   f_out_valid;
  logic                   f_out_ready;
  logic                   live;
  logic                   run;
  logic                   drain;
  logic                   accept;
  logic                   pool_ok;
  logic                   pool_fit;
  logic                   priv_fit;
  logic                   wd_restart;
  logic                   wd_expire;
  rba_pkg::rba_dec_t      dec;

  // ----------------------------------------
  // Response queue
  // ----------------------------------------
  rba_fifo #(
    .WIDTH (`RBA_RESP_W),
    .DEPTH (`RBA_RESP_DEPTH)
  ) u_resp_q (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (resp_data_o)
  );

  assign run    = (st_reg.mode == rba_pkg::RBA_RUN);
  assign drain  = (st_reg.mode == rba_pkg::RBA_DRAIN);
  assign live   = (st_reg.mode != rba_pkg::RBA_DEAD);
  assign accept = msg_valid_i && msg_ready_o;

  // Invalid-memory report takes the queue ahead of other responses
  assign f_in_valid  = run && (nxm_i || ext_valid_i);
  assign f_in_data   = nxm_i ? {`RBA_CODE_NXM, nxm_addr_i} : ext_data_i;
  assign ext_ready_o = run && f_in_ready && !nxm_i;
  assign f_out_ready = live && host_rd_i;

  assign resp_valid_o = live && f_out_valid;
  assign host_int_o   = live && f_out_valid;
  assign msg_ready_o  = run;
  assign overflow_o   = st_reg.overflow;
  assign shutdown_o   = !live;

  // ----------------------------------------
  // Read window timer
  // ----------------------------------------
  assign wd_restart = run || (drain && host_rd_i);

  rba_watchdog #(
    .CYCLES (WINDOW_CYCLES)
  ) u_wdog (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (wd_restart),
    .run_i     (drain),
    .expire_o  (wd_expire)
  );

  // ----------------------------------------
  // Buffer selection
  // ----------------------------------------
  // Receive path only; transmit buffers never reach this check
  assign pool_ok  = pool_en_i[msg_trib_i] && (pool_quota_i != 8'h00) && pool_avail_i;
  assign pool_fit = (pool_size_i >= msg_len_i);
  assign priv_fit = (priv_size_i >= msg_len_i);

  always_comb begin
    if (!msg_seq_ok_i) begin
      dec = rba_pkg::RBA_DEC_DISCARD;
    end else if (pool_ok && pool_fit) begin
      dec = rba_pkg::RBA_DEC_POOL;
    end else if (pool_ok) begin
      if (!priv_avail_i || !priv_fit) begin
        dec = rba_pkg::RBA_DEC_NAK_SMALL;
      end else begin
        dec = rba_pkg::RBA_DEC_PRIV;
      end
    end else if (!priv_avail_i) begin
      dec = rba_pkg::RBA_DEC_NAK_UNAVAIL;
    end else if (!priv_fit) begin
      dec = rba_pkg::RBA_DEC_NAK_SMALL;
    end else begin
      dec = rba_pkg::RBA_DEC_PRIV;
    end
  end

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.dec_valid = accept;
    st_next.pool_pop  = 1'b0;
    st_next.priv_pop  = 1'b0;
    st_next.ret_priv  = 1'b0;
    st_next.ret_pool  = 1'b0;
    if (accept) begin
      st_next.dec_kind = dec;
      st_next.dec_trib = msg_trib_i;
      // Head entry only, one pop per message
      st_next.pool_pop = (dec == rba_pkg::RBA_DEC_POOL);
      st_next.priv_pop = (dec == rba_pkg::RBA_DEC_PRIV);
    end
    if (live && halt_i) begin
      st_next.ret_priv = 1'b1;
      st_next.ret_trib = halt_trib_i;
    end
    if (live && global_halt_i) begin
      st_next.ret_pool = 1'b1;
    end
    unique case (st_reg.mode)
      rba_pkg::RBA_RUN: begin
        // No free entry for a response that cannot wait
        if (nxm_i && !f_in_ready) begin
          st_next.overflow = 1'b1;
          st_next.mode     = rba_pkg::RBA_DRAIN;
        end
      end
      rba_pkg::RBA_DRAIN: begin
        if (!f_out_valid || wd_expire) begin
          st_next.mode = rba_pkg::RBA_DEAD;
        end
      end
      rba_pkg::RBA_DEAD: begin
        st_next.mode = rba_pkg::RBA_DEAD;
      end
      default: begin
        st_next.mode = rba_pkg::RBA_DEAD;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_reg      <= '0;
      st_reg.mode <= rba_pkg::RBA_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dec_valid_o = st_reg.dec_valid;
  assign dec_kind_o  = st_reg.dec_kind;
  assign dec_trib_o  = st_reg.dec_trib;
  assign pool_pop_o  = st_reg.pool_pop;
  assign priv_pop_o  = st_reg.priv_pop;
  assign ret_priv_o  = st_reg.ret_priv;
  assign ret_trib_o  = st_reg.ret_trib;
  assign ret_pool_o  = st_reg.ret_pool;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_NXM_PUSH: assert property (
    run && nxm_i && f_in_ready |-> f_in_valid && f_in_data[`RBA_ADDR_W-1:0] == nxm_addr_i
      && f_in_data[`RBA_RESP_CODE_HI:`RBA_RESP_CODE_LO] == `RBA_CODE_NXM)
    else $error("Invalid memory response not queued");

  AST_DISCARD: assert property (
    accept && !msg_seq_ok_i |=> dec_valid_o && dec_kind_o == rba_pkg::RBA_DEC_DISCARD
      && !pool_pop_o && !priv_pop_o)
    else $error("Out of sequence message not discarded");

  AST_POOL_GATE: assert property (
    accept && (!pool_en_i[msg_trib_i] || pool_quota_i == 8'h00 || !pool_avail_i)
      |=> dec_kind_o != rba_pkg::RBA_DEC_POOL && !pool_pop_o)
    else $error("Pool used while unusable");

  AST_POOL_SMALL: assert property (
    accept && msg_seq_ok_i && pool_ok && !pool_fit && !priv_avail_i
      |=> dec_kind_o == rba_pkg::RBA_DEC_NAK_SMALL)
    else $error("Small pool buffer without private did not NAK small");

  AST_UNAVAIL: assert property (
    accept && msg_seq_ok_i && !pool_ok && !priv_avail_i
      |=> dec_kind_o == rba_pkg::RBA_DEC_NAK_UNAVAIL)
    else $error("Missing buffer did not NAK unavailable");

  AST_PRIV_SMALL: assert property (
    accept && msg_seq_ok_i && !pool_ok && priv_avail_i && !priv_fit
      |=> dec_kind_o == rba_pkg::RBA_DEC_NAK_SMALL && !priv_pop_o)
    else $error("Small private buffer accepted");

  AST_HALT_RET: assert property (
    live && halt_i |=> ret_priv_o && ret_trib_o == $past(halt_trib_i))
    else $error("Halt did not return buffers");

  AST_OVF_FATAL: assert property (
    run && nxm_i && !f_in_ready |=> drain && overflow_o ##1 !run [*3])
    else $error("Overflow not fatal");

  AST_DRAIN_INT: assert property (
    drain && f_out_valid |-> host_int_o && resp_valid_o)
    else $error("Drain response not presented");

  AST_DEAD_STAYS: assert property (
    drain && !f_out_valid |=> shutdown_o [*4])
    else $error("Shutdown not held after drain");

  AST_POOL_USE: assert property (
    accept && msg_seq_ok_i && pool_ok && pool_fit
      |=> dec_kind_o == rba_pkg::RBA_DEC_POOL && pool_pop_o)
    else $error("Usable pool buffer not taken");

  AST_FALLBACK: assert property (
    accept && msg_seq_ok_i && pool_ok && !pool_fit && priv_avail_i && priv_fit
      |=> dec_kind_o == rba_pkg::RBA_DEC_PRIV && priv_pop_o && !pool_pop_o)
    else $error("Small pool buffer did not fall back to private");

  AST_HEAD_ONLY: assert property (
    pool_pop_o || priv_pop_o |-> dec_valid_o && (pool_pop_o != priv_pop_o))
    else $error("Head entry taken outside a single decision");

  AST_SMALL_RX: assert property (
    accept && dec == rba_pkg::RBA_DEC_NAK_SMALL |-> !pool_fit || !priv_fit)
    else $error("Too small reported for a fitting receive buffer");

  AST_EXT_STALL: assert property (
    nxm_i |-> !ext_ready_o)
    else $error("Other response taken ahead of invalid memory report");

  AST_OVF_STICKY: assert property (
    overflow_o |=> overflow_o && !msg_ready_o)
    else $error("Overflow left without shutdown path");

  AST_WIN_RESTART: assert property (
    drain && host_rd_i |=> !wd_expire)
    else $error("Read window not restarted by host read");

  AST_WIN_EXPIRE: assert property (
    drain && wd_expire |=> shutdown_o)
    else $error("Window expiry did not shut down");

  AST_DEAD_QUIET: assert property (
    shutdown_o |=> shutdown_o && !resp_valid_o && !msg_ready_o)
    else $error("Shut down block became active");

  COV_POOL: cover property (accept ##1 dec_kind_o == rba_pkg::RBA_DEC_POOL);
  COV_FALLBACK: cover property (accept && pool_ok && !pool_fit ##1 priv_pop_o);
  COV_DRAIN_READ: cover property (drain && host_rd_i ##1 drain);
  COV_DEAD: cover property (drain ##1 shutdown_o);
  COV_EXPIRE: cover property (drain && wd_expire);
endmodule : rba_top

// File: rtl/rba_watchdog.sv
`timescale 1ns/1ns
`include "rba_regs.svh"
module rba_watchdog #(
  parameter logic [`RBA_WDOG_W-1:0] CYCLES = `RBA_WDOG_W'(`RBA_WINDOW_CYC)
) (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic restart_i,
  input  wire logic run_i,
  output logic      expire_o
);
  typedef struct packed {
    logic [`RBA_WDOG_W-1:0] cnt;
    logic                   expire;
  } rba_wdog_state_t;

  rba_wdog_state_t st_reg;
  rba_wdog_state_t st_next;

  assign expire_o = st_reg.expire;

  // Window restarts on every restart_i (run mode, or host read while draining), count clears when run_i is low
  always_comb begin
    st_next        = st_reg;
    st_next.expire = 1'b0;
    if (restart_i || !run_i) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == CYCLES - 1'b1) begin
      st_next.expire = 1'b1;
      st_next.cnt    = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : rba_watchdog

// File: testbench/rba_host_model.sv
`timescale 1ns/1ns
module rba_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  gap_i,
  input  wire logic        resp_valid_i,
  input  wire logic [19:0] resp_data_i,
  output logic             host_rd_o,
  output logic [19:0]      last_o,
  output logic [7:0]       rd_count_o
);
  logic [7:0] wait_reg;

  // ----------------------------------------
  // Host reads, prompt or slow by gap_i
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      host_rd_o  <= 1'b0;
      wait_reg   <= 8'h00;
      rd_count_o <= 8'h00;
      last_o     <= 20'h0_0000;
    end else if (host_rd_o) begin
      last_o     <= resp_data_i;
      rd_count_o <= rd_count_o + 8'h01;
      host_rd_o  <= 1'b0;
      wait_reg   <= 8'h00;
    end else if (rd_en_i && resp_valid_i) begin
      if (wait_reg >= gap_i) begin
        host_rd_o <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 8'h01;
      end
    end
  end
endmodule : rba_host_model

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic              seq;
    logic [1:0]        trib;
    logic [3:0]        en;
    logic [7:0]        quota;
    logic              pav;
    logic [15:0]       psz;
    logic              vav;
    logic [15:0]       vsz;
    rba_pkg::rba_dec_t kind;
    logic              pp;
    logic              vp;
  } rba_row_t;

  logic              ref_clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              msg_valid_i, msg_seq_ok_i, pool_avail_i, priv_avail_i, rd_en;
  logic              halt_i, global_halt_i, nxm_i, ext_valid_i, host_rd;
  logic              msg_ready_o, dec_valid_o, pool_pop_o, priv_pop_o, ret_priv_o;
  logic              ret_pool_o, ext_ready_o, resp_valid_o, host_int_o, overflow_o, shutdown_o;
  logic [1:0]        msg_trib_i, halt_trib_i, dec_trib_o, ret_trib_o;
  logic [15:0]       msg_len_i, pool_size_i, priv_size_i;
  logic [3:0]        pool_en_i;
  logic [7:0]        pool_quota_i, gap, rd_count;
  logic [17:0]       nxm_addr_i;
  logic [19:0]       ext_data_i, resp_data_o, last_rd;
  rba_pkg::rba_dec_t dec_kind_o;
  int                miscompares = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                n;
  rba_row_t          rows [9];

  rba_top #(.WINDOW_CYCLES(28'h000_0014)) u_rba_top (
    .ref_clk_i, .sys_rst_i, .msg_valid_i, .msg_ready_o, .msg_seq_ok_i, .msg_trib_i,
    .msg_len_i, .pool_en_i, .pool_quota_i, .pool_avail_i, .pool_size_i, .priv_avail_i,
    .priv_size_i, .dec_valid_o, .dec_kind_o, .dec_trib_o, .pool_pop_o, .priv_pop_o,
    .halt_i, .halt_trib_i, .global_halt_i, .ret_priv_o, .ret_trib_o, .ret_pool_o,
    .nxm_i, .nxm_addr_i, .ext_valid_i, .ext_ready_o, .ext_data_i, .resp_valid_o,
    .resp_data_o, .host_rd_i(host_rd), .host_int_o, .overflow_o, .shutdown_o);

  rba_host_model u_rba_host_model (
    .ref_clk_i, .sys_rst_i, .rd_en_i(rd_en), .gap_i(gap), .resp_valid_i(resp_valid_o),
    .resp_data_i(resp_data_o), .host_rd_o(host_rd), .last_o(last_rd), .rd_count_o(rd_count));

  always #10 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_reset;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    rd_en <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset

  // Fill queue past 16 entries, then let the host drain at gap g
  task automatic overflow_run(input logic [7:0] g, output int cnt);
    int k;
    do_reset();
    for (k = 0; k <= 16; k++) begin
      @(posedge ref_clk_i);
      nxm_i <= 1'b1;
      nxm_addr_i <= 18'(k);
    end
    @(posedge ref_clk_i);
    nxm_i <= 1'b0;
    gap <= g;
    rd_en <= 1'b1;
    #1;
    check("overflow", 1, overflow_o);
    check("msg_ready", 0, msg_ready_o);
    check("ext_ready_ovf", 0, ext_ready_o);
    check("first_resp", 20'h4_0000, resp_data_o);
    for (cnt = 0; cnt < 600 && shutdown_o !== 1'b1; cnt++) begin
      @(posedge ref_clk_i);
    end
  endtask : overflow_run

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {msg_valid_i, msg_seq_ok_i, pool_avail_i, priv_avail_i, rd_en} = '0;
    {halt_i, global_halt_i, nxm_i, ext_valid_i, msg_trib_i, halt_trib_i} = '0;
    {msg_len_i, pool_size_i, priv_size_i, pool_en_i, pool_quota_i, gap} = '0;
    nxm_addr_i = 18'h0_0000;
    ext_data_i = 20'h0_0000;
    rows[0] = '{1'b0, 2'h1, 4'h2, 8'h01, 1'b1, 16'h0080, 1'b1, 16'h0080,
                rba_pkg::RBA_DEC_DISCARD, 1'b0, 1'b0};
    rows[1] = '{1'b1, 2'h1, 4'h2, 8'h01, 1'b1, 16'h0040, 1'b1, 16'h0080,
                rba_pkg::RBA_DEC_POOL, 1'b1, 1'b0};
    rows[2] = '{1'b1, 2'h3, 4'h7, 8'h01, 1'b1, 16'h0080, 1'b1, 16'h0040,
                rba_pkg::RBA_DEC_PRIV, 1'b0, 1'b1};
    rows[3] = '{1'b1, 2'h0, 4'hF, 8'h00, 1'b1, 16'h0080, 1'b1, 16'h0080,
                rba_pkg::RBA_DEC_PRIV, 1'b0, 1'b1};
    rows[4] = '{1'b1, 2'h2, 4'hF, 8'h01, 1'b0, 16'h0080, 1'b0, 16'h0080,
                rba_pkg::RBA_DEC_NAK_UNAVAIL, 1'b0, 1'b0};
    rows[5] = '{1'b1, 2'h0, 4'h1, 8'hFF, 1'b1, 16'h003F, 1'b1, 16'h0080,
                rba_pkg::RBA_DEC_PRIV, 1'b0, 1'b1};
    rows[6] = '{1'b1, 2'h0, 4'h1, 8'h01, 1'b1, 16'h003F, 1'b0, 16'h0080,
                rba_pkg::RBA_DEC_NAK_SMALL, 1'b0, 1'b0};
    rows[7] = '{1'b1, 2'h1, 4'h2, 8'h01, 1'b1, 16'h003F, 1'b1, 16'h003F,
                rba_pkg::RBA_DEC_NAK_SMALL, 1'b0, 1'b0};
    rows[8] = '{1'b1, 2'h2, 4'h0, 8'h01, 1'b1, 16'h0080, 1'b1, 16'h003F,
                rba_pkg::RBA_DEC_NAK_SMALL, 1'b0, 1'b0};
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    // Back-to-back messages, each of length 16'h0040
    for (int i = 0; i <= 9; i++) begin
      @(posedge ref_clk_i);
      msg_valid_i <= (i < 9);
      if (i < 9) begin
        {msg_seq_ok_i, msg_trib_i, pool_en_i, pool_quota_i, pool_avail_i} <= rows[i][53:38];
        {pool_size_i, priv_avail_i, priv_size_i} <= rows[i][37:5];
        msg_len_i <= 16'h0040;
      end
      #1;
      if (i > 0) begin
        check("dec_valid", 1, dec_valid_o);
        check("dec_kind", rows[i-1].kind, dec_kind_o);
        check("dec_trib", rows[i-1].trib, dec_trib_o);
        check("pops", {rows[i-1].pp, rows[i-1].vp}, {pool_pop_o, priv_pop_o});
      end
    end
    $display("test selection done");
    do_reset();
    @(posedge ref_clk_i);
    halt_i <= 1'b1;
    halt_trib_i <= 2'h2;
    #1;
    check("rst_ready", 1, msg_ready_o);
    check("rst_shut", 0, {shutdown_o, resp_valid_o, dec_valid_o});
    @(posedge ref_clk_i);
    halt_i <= 1'b0;
    global_halt_i <= 1'b1;
    #1;
    check("ret_priv", 3'h6, {ret_priv_o, ret_trib_o});
    @(posedge ref_clk_i);
    global_halt_i <= 1'b0;
    nxm_i <= 1'b1;
    nxm_addr_i <= 18'h2_ABCD;
    #1;
    check("ret_pool", 2'h1, {ret_priv_o, ret_pool_o});
    check("ext_stall", 0, ext_ready_o);
    $display("test halt done");
    @(posedge ref_clk_i);
    nxm_i <= 1'b0;
    ext_valid_i <= 1'b1;
    ext_data_i <= 20'h2_1234;
    #1;
    check("int", 2'h3, {resp_valid_o, host_int_o});
    check("nxm_word", 20'h6_ABCD, resp_data_o);
    check("ext_ready", 1, ext_ready_o);
    @(posedge ref_clk_i);
    ext_valid_i <= 1'b0;
    rd_en <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1;
    check("reads", 2, rd_count);
    check("ext_word", 20'h2_1234, last_rd);
    check("empty", 0, resp_valid_o);
    $display("test response done");
    overflow_run(8'h0A, n);
    #1;
    check("shutdown", 1, shutdown_o);
    check("drained", 16, rd_count);
    check("last_word", 20'h4_000F, last_rd);
    repeat (4) @(posedge ref_clk_i);
    #1;
    check("dead", 3'h4, {shutdown_o, resp_valid_o, msg_ready_o});
    $display("test drain done");
    overflow_run(8'h28, n);
    #1;
    check("expire", 1, shutdown_o);
    check("no_reads", 0, rd_count);
    check("window", 1, n >= 18 && n <= 24);
    $display("test expiry done");
    report_and_stop();
  end
endmodule : tb_top
